// ==== pope_checker.sv ====
// Checker for the pin-output and event-poll execution block.
// Assumes it is bound to pope_exec and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module pope_checker (
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // Instruction side
    input wire logic [8:0] instr_dest,
    input wire logic [8:0] instr_src,
    input wire logic       instr_c_eff,
    input wire logic       instr_done,
    input wire logic       carry_q,
    // Event side
    input wire logic       atn_req,
    input wire logic       int_taken,
    input wire logic       int_is_debug,
    input wire logic       fifo_block_wrap,
    input wire logic       pin_pattern_hit,
    input wire logic       fifo_setup_op,
    input wire logic [6:0] event_flags
);
    // One domain: core clock, async reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_DONE_PULSE: assert property (instr_done |=> !instr_done)
        else $error("done longer than one cycle");
    AST_ATN_SET: assert property (atn_req |=> event_flags[6])
        else $error("attention flag not set");
    AST_INT_SET: assert property (int_taken && !int_is_debug |=> event_flags[0])
        else $error("interrupt flag not set");
    AST_INT_DBG: assert property (int_taken && int_is_debug && !event_flags[0] |=> !event_flags[0])
        else $error("debug interrupt set the flag");
    AST_FBW_SET: assert property (fifo_block_wrap |=> event_flags[5])
        else $error("block wrap flag not set");
    AST_PAT_SET: assert property (pin_pattern_hit |=> event_flags[4])
        else $error("pattern flag not set");
    AST_FBW_CLR: assert property (fifo_setup_op && !fifo_block_wrap |=> !event_flags[5])
        else $error("block wrap flag not cleared");
    AST_POLL_ATN: assert property (instr_done && instr_src == 9'h024 && instr_dest == 9'h00e
        && instr_c_eff && !atn_req && $stable(event_flags[6])
        |=> carry_q == $past(event_flags[6]) && !event_flags[6])
        else $error("attention poll wrong");
endmodule // pope_checker
bind pope_exec pope_checker u_chk (.clk, .reset_n, .instr_dest, .instr_src, .instr_c_eff,
    .instr_done, .carry_q, .atn_req, .int_taken, .int_is_debug, .fifo_block_wrap,
    .pin_pattern_hit, .fifo_setup_op, .event_flags);
`default_nettype wire

// ==== pope_defs.vh ====
// Constants for the pin-output and event-poll execution block.
// Assumes one core clock and instruction fields presented by the fetch stage.
`ifndef POPE_DEFS_VH
`define POPE_DEFS_VH

`define POPE_OPC_PIN        7'h6b
`define POPE_SRC_RND        9'h04e
`define POPE_SRC_ZERO       9'h04c
`define POPE_SRC_NZERO      9'h04d
`define POPE_SRC_POLL       9'h024
`define POPE_EV_INT         9'h000
`define POPE_EV_CT1         9'h001
`define POPE_EV_CT2         9'h002
`define POPE_EV_CT3         9'h003
`define POPE_EV_PAT         9'h008
`define POPE_EV_FBW         9'h009
`define POPE_EV_ATN         9'h00e
`define POPE_EXEC_CYCLES    2'h2
`define POPE_OUT_RESET      32'h00000000
`define POPE_LFSR_SEED      64'h0123456789abcdef

`endif

// ==== pope_event_src.sv ====
// Event sensor stand-in: turns bench commands into one-cycle sensor pulses.
// Assumes the core clock; the system counter free-runs from reset.
`timescale 1ns/1ps
`default_nettype none
module pope_event_src (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Commands {pat, fbw, dbg, int, atn}
    input  wire logic [4:0]  fire,
    // Sensor pulses in the same order, and the counter
    output var  logic [4:0]  sense,
    output var  logic [31:0] system_counter
);
    // Pulses start on an edge, one cycle after the command
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sense          <= 5'h00;
            system_counter <= 32'h00000000;
        end else begin
            sense          <= fire;
            system_counter <= system_counter + 32'h00000001;
        end
    end
endmodule // pope_event_src
`default_nettype wire

// ==== pope_exec.v ====
// Execution unit for pin-output and event-poll instructions of one core.
// Assumes the fetch stage holds instr_valid with stable fields until instr_done.
`timescale 1ns/1ps
`default_nettype none
`include "pope_defs.vh"

module pope_exec (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // Core start clears attention and interrupt flags
    input  wire        core_start,
    // Instruction issue
    input  wire        instr_valid,
    input  wire [6:0]  instr_opcode,
    input  wire [8:0]  instr_dest,
    input  wire [8:0]  instr_src,
    input  wire        instr_dest_imm,
    input  wire        instr_c_eff,
    input  wire        instr_z_eff,
    input  wire [31:0] dest_reg_value,
    input  wire        augment_valid,
    input  wire [1:0]  augment_bits,
    input  wire        queue_prev,
    input  wire [4:0]  queue_dest,
    output wire        instr_done,
    // Condition flags
    output reg         carry_q,
    output reg         zero_q,
    // Port output registers
    output reg  [31:0] port_low_output_reg,
    output reg  [31:0] port_high_output_reg,
    // Event sensors, one-cycle set pulses, plus the system counter and its three compare triggers
    input  wire        atn_req,
    input  wire        int_taken,
    input  wire        int_is_debug,
    input  wire [31:0] system_counter,
    input  wire [31:0] counter_trigger_one,
    input  wire [31:0] counter_trigger_two,
    input  wire [31:0] counter_trigger_three,
    input  wire        fifo_block_wrap,
    input  wire        pin_pattern_hit,
    // Other instructions that clear event flags
    input  wire        wait_or_jump_int,
    input  wire        wait_or_jump_atn,
    input  wire [2:0]  ct_clear_ops,
    input  wire        fifo_setup_op,
    input  wire        pin_pattern_setup_op,
    // Event flag view
    output wire [6:0]  event_flags
);
    localparam ST_IDLE = 1'b0;   // Waiting for an instruction
    localparam ST_EXEC = 1'b1;   // Second clock, commit

    reg        state_q;          // Sequencer state
    reg        int_q;            // Interrupt-occurred flag
    reg  [2:0] ct_q;             // Counter event flags
    reg        pat_q;            // Pin-pattern flag
    reg        fbw_q;            // FIFO block-wrap flag
    reg        atn_q;            // Attention flag
    reg  [2:0] ct_msb_q;         // Previous compare sign bits
    wire [31:0] rnd_word;        // Random bits
    wire [31:0] d1;              // Counter differences
    wire [31:0] d2;
    wire [31:0] d3;
    wire [2:0] ct_msb;
    wire [2:0] ct_set;           // Compare just reached zero sign
    reg  [10:0] pin_op;          // Resolved 11-bit pin range
    reg  [31:0] sel_mask;        // Selected bits inside the port
    reg  [31:0] port_cur;        // Port addressed by the base
    reg  [31:0] port_new;        // Port value after the write
    reg  [4:0]  pin_off;         // Pin offset from the base, modulo 32
    reg         base_bit;        // Original base bit
    reg         ev_val;          // Polled event value
    reg  [6:0]  poll_clr;        // Poll-driven clears
    wire        is_pin;
    wire        is_poll;
    wire        go;
    integer     i;

    // The fetch stage keeps the fields steady over both clocks of an
    // instruction, so this decode serves at take and again at commit.
    // Any other opcode or source code belongs to another unit: it is
    // never taken here and raises no done pulse.
    // The event view is a plain join of registered flags.
    // Decoded instruction classes
    assign is_pin  = (instr_opcode == `POPE_OPC_PIN) &&
                     ((instr_src == `POPE_SRC_RND) || (instr_src == `POPE_SRC_ZERO) ||
                      (instr_src == `POPE_SRC_NZERO));
    assign is_poll = (instr_opcode == `POPE_OPC_PIN) && (instr_src == `POPE_SRC_POLL);
    assign go          = (state_q == ST_EXEC);
    assign instr_done  = go;
    assign event_flags = {atn_q, fbw_q, pat_q, ct_q, int_q};

    // The generator steps on every clock, busy or not, so two random ops
    // issued close together still draw unrelated words. A fixed seed
    // means the same sequence after every reset. Only the top half of
    // the scrambled word reaches the pins.
    // Generator instance
    pope_rng u_rng (
        .clk      (clk),
        .reset_n  (reset_n),
        .rnd_word (rnd_word)
    );

    // A counter flag rises on the clock in which the sign of counter minus
    // trigger falls from one to zero. Watching the fall rather than the
    // level keeps a trigger that is already behind the counter from
    // raising the flag again on every clock after a clear. The sign
    // register resets to zero, so leaving reset never looks like a fall.
    // Moving a trigger ahead of the counter gives a rise, which is ignored.
    // compare sign edge detect
    assign d1 = system_counter - counter_trigger_one;
    assign d2 = system_counter - counter_trigger_two;
    assign d3 = system_counter - counter_trigger_three;
    assign ct_msb = {d3[31], d2[31], d1[31]};
    assign ct_set = ct_msb_q & ~ct_msb;

    // The pin operand is 11 bits: base pin in 5:0, extra pins in 10:6,
    // and bit 5 picks the port. An immediate only reaches 8:6; the augment
    // prefix fills 10:9, and the queue prefix replaces the whole count of
    // a register operand. The mask is worked out modulo 32, so a range
    // that runs past the last pin of a port folds back to its first pin
    // and never touches the other port. The same mask serves all three
    // pin ops, so the random op wraps in exactly the same way.
    // Resolve pin operand and port write
    always @* begin
        if (instr_dest_imm) begin
            pin_op = augment_valid ? {augment_bits, instr_dest} : {2'h0, instr_dest};
        end else begin
            pin_op = dest_reg_value[10:0];
            if (queue_prev) begin
                pin_op[10:6] = queue_dest;
            end
        end
        port_cur = pin_op[5] ? port_high_output_reg : port_low_output_reg;
        sel_mask = 32'h00000000;
        pin_off  = 5'h00;
        // random op wraps the same way
        for (i = 0; i < 32; i = i + 1) begin
            // Five-bit difference, so the offset folds modulo 32
            pin_off = i[4:0] - pin_op[4:0];
            if (pin_off <= pin_op[10:6]) begin
                sel_mask[i] = 1'b1;
            end
        end
        base_bit = port_cur[pin_op[4:0]];
        if (instr_src == `POPE_SRC_RND) begin
            port_new = (port_cur & ~sel_mask) | (rnd_word & sel_mask);
        end else if (instr_src == `POPE_SRC_ZERO) begin
            port_new = (port_cur & ~sel_mask) | ({32{zero_q}} & sel_mask);
        end else begin
            port_new = (port_cur & ~sel_mask) | ({32{~zero_q}} & sel_mask);
        end
    end

    // Only the event code of the current instruction is looked at. An
    // unlisted code reads as zero and clears nothing. The clear is held
    // back to the commit clock so that the value copied into the flags is
    // the one from before the clear.
    // Select polled flag and its clear
    always @* begin
        ev_val   = 1'b0;
        poll_clr = 7'h00;
        if (instr_dest == `POPE_EV_INT) begin
            ev_val = int_q;
            poll_clr[0] = 1'b1;
        end else if (instr_dest == `POPE_EV_CT1) begin
            ev_val = ct_q[0];
            poll_clr[1] = 1'b1;
        end else if (instr_dest == `POPE_EV_CT2) begin
            ev_val = ct_q[1];
            poll_clr[2] = 1'b1;
        end else if (instr_dest == `POPE_EV_CT3) begin
            ev_val = ct_q[2];
            poll_clr[3] = 1'b1;
        end else if (instr_dest == `POPE_EV_PAT) begin
            ev_val = pat_q;
            poll_clr[4] = 1'b1;
        end else if (instr_dest == `POPE_EV_FBW) begin
            ev_val = fbw_q;
            poll_clr[5] = 1'b1;
        end else if (instr_dest == `POPE_EV_ATN) begin
            ev_val = atn_q;
            poll_clr[6] = 1'b1;
        end
        if (!(go && is_poll)) begin
            poll_clr = 7'h00;
        end
    end

    // Take in idle, commit one clock later, then idle again. A request
    // still raised on the commit clock is not taken a second time there;
    // the fetch stage lowers it or brings the next instruction after done.
    // Back-to-back instructions therefore cost two clocks each.
    // two-clock sequencer
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (instr_valid && (is_pin || is_poll)) begin
                        state_q <= ST_EXEC;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // The base bit and the polled flag are read from the registers as they
    // stand before this edge, so the flags always get the old values. A pin
    // op with only one of the two effects leaves both flags alone; a poll
    // may load either flag or both.
    // Ports and condition flags commit in the second clock
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port_low_output_reg  <= `POPE_OUT_RESET;
            port_high_output_reg <= `POPE_OUT_RESET;
            carry_q              <= 1'b0;
            zero_q               <= 1'b0;
        end else if (go && is_pin) begin
            if (pin_op[5]) begin
                port_high_output_reg <= port_new;
            end else begin
                port_low_output_reg <= port_new;
            end
            // both flags take original base bit
            if (instr_c_eff && instr_z_eff) begin
                carry_q <= base_bit;
                zero_q  <= base_bit;
            end
        end else if (go && is_poll) begin
            if (instr_c_eff) begin
                carry_q <= ev_val;
            end
            if (instr_z_eff) begin
                zero_q <= ev_val;
            end
        end
    end

    // Every flag has the same form: its set term or-ed with its held value
    // masked by its clears. A sensor pulse that lands on a clear therefore
    // keeps the flag up and no event is lost. Core start only reaches the
    // attention and interrupt flags.
    // Event flags; a set in the clearing cycle wins
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            int_q    <= 1'b0;
            ct_q     <= 3'h0;
            pat_q    <= 1'b0;
            fbw_q    <= 1'b0;
            atn_q    <= 1'b0;
            ct_msb_q <= 3'h0;
        end else begin
            ct_msb_q <= ct_msb;
            int_q <= (int_taken && !int_is_debug) ||
                     (int_q && !(core_start || wait_or_jump_int || poll_clr[0]));
            // counter flags clear on own ops
            ct_q  <= ct_set | (ct_q & ~(ct_clear_ops | poll_clr[3:1]));
            pat_q <= pin_pattern_hit ||
                     (pat_q && !(pin_pattern_setup_op || poll_clr[4]));
            fbw_q <= fifo_block_wrap || (fbw_q && !(fifo_setup_op || poll_clr[5]));
            atn_q <= atn_req ||
                     (atn_q && !(core_start || wait_or_jump_atn || poll_clr[6]));
        end
    end
endmodule // pope_exec

`default_nettype wire

// ==== pope_rng.v ====
// Pseudo-random bit source for the random pin-output instruction.
// Assumes one clock; advances every cycle so each instruction sees fresh bits.
`timescale 1ns/1ps
`default_nettype none
`include "pope_defs.vh"

module pope_rng (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // Random word
    output wire [31:0] rnd_word
);
    reg  [63:0] s0_q;   // State half 0
    reg  [63:0] s1_q;   // State half 1
    wire [63:0] x1;     // Mixed second half
    wire [63:0] s0_d;
    wire [63:0] s1_d;
    wire [63:0] mul5;   // Scrambler stage
    wire [63:0] rot7;
    wire [63:0] mul9;

    // Two-word shift-xor state update
    assign x1   = s1_q ^ s0_q;
    assign s0_d = {s0_q[39:0], s0_q[63:40]} ^ x1 ^ {x1[47:0], 16'h0000};
    assign s1_d = {x1[26:0], x1[63:27]};
    // Scrambled output: rotate of times five, times nine
    assign mul5 = {s0_q[61:0], 2'h0} + s0_q;
    assign rot7 = {mul5[56:0], mul5[63:57]};
    assign mul9 = {rot7[60:0], 3'h0} + rot7;
    assign rnd_word = mul9[63:32];

    // State register
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s0_q <= `POPE_LFSR_SEED;
            s1_q <= 64'hfedcba9876543210;
        end else begin
            s0_q <= s0_d;
            s1_q <= s1_d;
        end
    end
endmodule // pope_rng

`default_nettype wire

// ==== tb_pin_output_and_event_poll_exec.sv ====
// Self-checking bench for the pin-output and event-poll block.
// Assumes pope_exec, pope_event_src and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "pope_defs.vh"
module tb_pin_output_and_event_poll_exec;
    logic        clk, reset_n, instr_valid, instr_dest_imm, instr_c_eff, instr_z_eff;
    logic        augment_valid, queue_prev;
    logic [1:0]  augment_bits;
    logic [4:0]  queue_dest, fire;
    logic [7:0]  clr; // {start, wj_int, wj_atn, ct3, ct2, ct1, fifo, pat}
    logic [8:0]  instr_dest, instr_src;
    logic [31:0] dest_reg_value, trig;
    logic [6:0]  ex, opc;
    wire  logic  instr_done, carry_q, zero_q;
    wire  logic [4:0]  sense;
    wire  logic [6:0]  event_flags;
    wire  logic [31:0] lo, hi, ct;
    int          err_count, n_checks, k;
    int          bm [7] = '{4, 5, 1, 2, 3, 6, 0};
    logic [8:0]  pd [7] = '{9'h008, 9'h009, 9'h001, 9'h002, 9'h003, 9'h00e, 9'h000};
    pope_exec dut (.clk(clk), .reset_n(reset_n), .core_start(clr[7]), .instr_valid(instr_valid),
        .instr_opcode(opc), .instr_dest(instr_dest), .instr_src(instr_src),
        .instr_dest_imm(instr_dest_imm), .instr_c_eff(instr_c_eff), .instr_z_eff(instr_z_eff),
        .dest_reg_value(dest_reg_value), .augment_valid(augment_valid),
        .augment_bits(augment_bits), .queue_prev(queue_prev), .queue_dest(queue_dest),
        .instr_done(instr_done), .carry_q(carry_q), .zero_q(zero_q),
        .port_low_output_reg(lo), .port_high_output_reg(hi), .atn_req(sense[0]),
        .int_taken(sense[1]), .int_is_debug(sense[2]), .system_counter(ct),
        .counter_trigger_one(trig), .counter_trigger_two(trig), .counter_trigger_three(trig),
        .fifo_block_wrap(sense[3]), .pin_pattern_hit(sense[4]), .wait_or_jump_int(clr[6]),
        .wait_or_jump_atn(clr[5]), .ct_clear_ops(clr[4:2]), .fifo_setup_op(clr[1]),
        .pin_pattern_setup_op(clr[0]), .event_flags(event_flags));
    pope_event_src u_src (.clk(clk), .reset_n(reset_n), .fire(fire), .sense(sense),
        .system_counter(ct));
    // 100 ns core clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Hang guard, far beyond the expected run
    initial begin
        #2000000;
        err_count++;
        test_done;
    end
    task chk(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One instruction: hold until done, drop at the commit edge
    task run(input logic [8:0] src, input logic [8:0] dst, input logic i, c, z);
        k = 0;
        @(posedge clk);
        {instr_valid, instr_src, instr_dest, instr_dest_imm, instr_c_eff, instr_z_eff}
            <= {1'b1, src, dst, i, c, z};
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (instr_done !== 1'b1 && k < 8);
        chk("latency", k, 32'd1);
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
    endtask
    // One-cycle clear strobes and sensor commands, then settle
    task pulse(input logic [7:0] c, input logic [4:0] f);
        @(posedge clk);
        {clr, fire} <= {c, f};
        @(posedge clk);
        {clr, fire} <= 13'h0000;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {instr_valid, instr_dest_imm, instr_c_eff, instr_z_eff, augment_valid, queue_prev} = '0;
        {augment_bits, queue_dest, fire, clr, instr_dest, instr_src, dest_reg_value} = '0;
        trig = 32'h00000100;
        opc = `POPE_OPC_PIN;
        reset_n = 1'b0;
        err_count = 0;
        n_checks = 0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk("reset ports", lo | hi, 32'h0);
        chk("reset flags", 32'({carry_q, zero_q, event_flags}), 32'h0);
        run(`POPE_SRC_NZERO, {3'h3, 6'h1e}, 1'b1, 1'b0, 1'b0);
        chk("lo wrap", lo, 32'hc0000003);
        @(posedge clk) dest_reg_value <= 32'h00000005;
        run(`POPE_SRC_NZERO, 9'h000, 1'b0, 1'b0, 1'b0);
        chk("lo reg", lo, 32'hc0000023);
        @(posedge clk) {queue_prev, queue_dest, dest_reg_value} <= {1'b1, 5'h04, 32'h000007e8};
        run(`POPE_SRC_NZERO, 9'h000, 1'b0, 1'b0, 1'b0);
        chk("hi queue", hi, 32'h00001f00);
        @(posedge clk) {queue_prev, augment_valid, augment_bits} <= {1'b0, 1'b1, 2'h2};
        run(`POPE_SRC_NZERO, {3'h1, 6'h32}, 1'b1, 1'b0, 1'b0);
        chk("hi augment", hi, 32'hfffc1f0f);
        @(posedge clk) augment_valid <= 1'b0;
        run(`POPE_SRC_ZERO, 9'h01f, 1'b1, 1'b1, 1'b1);
        chk("lo base", lo, 32'h40000023);
        chk("c z base", 32'({carry_q, zero_q}), 32'h3);
        run(`POPE_SRC_ZERO, 9'h002, 1'b1, 1'b0, 1'b0);
        run(`POPE_SRC_NZERO, 9'h001, 1'b1, 1'b0, 1'b0);
        chk("lo z", lo, 32'h40000025);
        run(`POPE_SRC_RND, {3'h7, 6'h3c}, 1'b1, 1'b0, 1'b0);
        chk("hi rnd", hi & 32'h0ffffff0, 32'h0ffc1f00);
        chk("lo kept", lo, 32'h40000025);
        @(posedge clk) {opc, instr_valid, instr_src, instr_dest}
            <= {7'h6a, 1'b1, `POPE_SRC_NZERO, 9'h000};
        @(posedge clk);
        #1;
        chk("refused done", 32'(instr_done), 32'h0);
        repeat (2) @(posedge clk);
        #1;
        chk("refused lo", lo, 32'h40000025);
        @(posedge clk) {opc, instr_valid} <= {`POPE_OPC_PIN, 1'b0};
        $display("test pins end");
        repeat (300) @(posedge clk);
        #1;
        chk("ct flags", 32'(event_flags), 32'h0e);
        pulse(8'h00, 5'h06);
        chk("dbg ignored", 32'(event_flags), 32'h0e);
        pulse(8'h00, 5'h1b);
        ex = 7'h7f;
        chk("all set", 32'(event_flags), 32'(ex));
        for (int i = 0; i < 7; i++) begin
            pulse(8'h01 << i, 5'h00);
            ex[bm[i]] = 1'b0;
            chk("clear op", 32'(event_flags), 32'(ex));
        end
        pulse(8'h00, 5'h03);
        pulse(8'h80, 5'h00);
        chk("start", 32'(event_flags), 32'h0);
        @(posedge clk) fire <= 5'h01;
        @(posedge clk) {fire, clr} <= {5'h00, 8'h20};
        @(posedge clk) {clr, trig} <= {8'h00, ct + 32'h00000008};
        #1;
        chk("set wins atn", 32'(event_flags[6]), 32'h1);
        pulse(8'h00, 5'h1b);
        repeat (8) @(posedge clk);
        #1;
        chk("set wins", 32'(event_flags), 32'h7f);
        for (int i = 0; i < 7; i++) begin
            run(`POPE_SRC_POLL, pd[i], 1'b0, 1'b1, 1'b1);
            chk("poll read", 32'({carry_q, zero_q, event_flags[bm[i]]}), 32'h6);
            run(`POPE_SRC_POLL, pd[i], 1'b0, 1'b1, 1'b1);
            chk("poll again", 32'({carry_q, zero_q}), 32'h0);
        end
        pulse(8'h00, 5'h01);
        run(`POPE_SRC_POLL, 9'h00e, 1'b0, 1'b1, 1'b0);
        chk("poll c", 32'({carry_q, zero_q}), 32'h2);
        pulse(8'h00, 5'h02);
        run(`POPE_SRC_POLL, 9'h000, 1'b0, 1'b0, 1'b1);
        chk("poll z", 32'({carry_q, zero_q}), 32'h3);
        $display("test events end");
        test_done;
    end
endmodule // tb_pin_output_and_event_poll_exec
`default_nettype wire
